/* core/cmp_vref_ctrl.sv */
/*
  Comparator and voltage reference control with APB register access,
  comparator change interrupt and Sleep wake request.
  Assumes analog comparators and resistor ladder outside, all inputs
  synchronous to pclk, and an APB master per the AMBA protocol.
*/
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Function
// - Comparators and interrupt stay active in Sleep
// - Enabled comparator interrupt wakes from Sleep
// - Mode 111 switches both comparators off
// - Control register unchanged by Sleep wake
// - Reset loads mode 111, comparators off
// - Port pins analog at reset; any nonzero config makes all four read digital
// - Two ranges, sixteen levels each
// - Ladder ratio set by range and level
// - Bit 4 selects supply rails or pins
// - Bit 7 powers resistor ladder
// - Reference independent of comparator mode
// - Oscillator pins read zero when claimed
// - Pin enable connects reference to pin 2
// - Reset clears reference control bits
// - Comparator result bits are read-only
module cmp_vref_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  input wire logic osc_claims_pins,
  input wire logic [1:0] cmp_raw,
  input wire logic [7:0] port_a_pins,
  output logic [2:0] comparator_mode_field,
  output logic comparator_input_switch,
  output logic [1:0] comparator_enable,
  output logic vref_power_enable,
  output logic vref_pin_output_enable,
  output logic vref_range_select,
  output logic vref_source_select,
  output logic [3:0] vref_level_code,
  output logic [3:0] port_analog_config,
  output logic irq,
  output logic irq_high_priority,
  output logic wake
);
  // Offsets reach 0x1C, so five address bits are the least
  if (ADDR_W < 5) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  //////////////////////////////////////////////////////////////////
  logic [7:0] cmp_ctrl_reg;
  logic [7:0] vref_ctrl_reg;
  logic [7:0] int_flags_reg;
  logic [7:0] int_en_reg;
  logic [7:0] int_prio_reg;
  logic [3:0] port_cfg_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic irq_hi_reg;
  logic wake_reg;
  logic [1:0] cmp_en_reg;
  logic change_q;
  logic setup;
  logic wr;
  logic mapped;
  logic [7:0] addr8;
  logic [7:0] cmp_rd;
  logic [7:0] port_view;
  logic cmp_event;
  cmp_res_if res ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Narrow buses are zero-extended, wide ones cut to the map
  assign addr8 = 8'(paddr);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = hit(addr8, cmp_vref_pkg::OFS_CMP_CTRL) || hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL)
    || hit(addr8, cmp_vref_pkg::OFS_INT_FLAGS) || hit(addr8, cmp_vref_pkg::OFS_INT_EN)
    || hit(addr8, cmp_vref_pkg::OFS_INT_PRIO) || hit(addr8, cmp_vref_pkg::OFS_INT_CLEAR)
    || hit(addr8, cmp_vref_pkg::OFS_PORT_CFG) || hit(addr8, cmp_vref_pkg::OFS_PORT_VIEW);

  cmp_result_track u_track (
    .pclk(pclk),
    .presetn(presetn),
    .cmp_raw(cmp_raw),
    .invert({cmp_ctrl_reg[cmp_vref_pkg::CMP_BIT_COMPARATOR2_INVERT],
             cmp_ctrl_reg[cmp_vref_pkg::CMP_BIT_COMPARATOR1_INVERT]}),
    .cmp_on(cmp_ctrl_reg[2:0] != cmp_vref_pkg::MODE_OFF),
    .res(res.tracker)
  );
  // Any access to the control register ends the mismatch
  assign res.ack = psel && penable && hit(addr8, cmp_vref_pkg::OFS_CMP_CTRL);

  //////////////////////////////////////////////////////////////////
  // Comparator control; Sleep has no path here so contents survive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ctrl_reg <= cmp_vref_pkg::CMP_CTRL_RESET;
    end else if (wr && hit(addr8, cmp_vref_pkg::OFS_CMP_CTRL) && pstrb[0]) begin
      // Result bits stay under hardware control
      cmp_ctrl_reg <= pwdata[7:0] & cmp_vref_pkg::CMP_WRITABLE;
    end
  end

  // Comparator power, unaffected by sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_en_reg <= 2'h0;
    end else begin
      cmp_en_reg <= (cmp_ctrl_reg[2:0] == cmp_vref_pkg::MODE_OFF) ? 2'h0 : 2'h3;
    end
  end

  // Reference control, written regardless of comparator mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_ctrl_reg <= cmp_vref_pkg::VREF_CTRL_RESET;
    end else if (wr && hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL) && pstrb[0]) begin
      vref_ctrl_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_cfg_reg <= cmp_vref_pkg::PORT_CFG_RESET;
    end else if (wr && hit(addr8, cmp_vref_pkg::OFS_PORT_CFG) && pstrb[0]) begin
      port_cfg_reg <= pwdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////
  // Interrupt flags: hardware set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_q <= 1'b0;
    end else begin
      change_q <= res.change;
    end
  end
  // Mismatch keeps setting the flag while present
  assign cmp_event = res.change;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flags_reg <= cmp_vref_pkg::INT_RESET;
    end else begin
      if (wr && hit(addr8, cmp_vref_pkg::OFS_INT_FLAGS) && pstrb[0]) begin
        int_flags_reg <= pwdata[7:0] & cmp_vref_pkg::INT_WRITABLE;
      end else if (wr && hit(addr8, cmp_vref_pkg::OFS_INT_CLEAR) && pstrb[0]) begin
        int_flags_reg <= int_flags_reg & ~pwdata[7:0];
      end
      if (cmp_event) begin
        int_flags_reg[cmp_vref_pkg::INT_BIT_CMP] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_reg <= cmp_vref_pkg::INT_RESET;
    end else if (wr && hit(addr8, cmp_vref_pkg::OFS_INT_EN) && pstrb[0]) begin
      int_en_reg <= pwdata[7:0] & cmp_vref_pkg::INT_WRITABLE;
    end
  end

  // Priority only steers the high line; it never masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_prio_reg <= cmp_vref_pkg::INT_RESET;
    end else if (wr && hit(addr8, cmp_vref_pkg::OFS_INT_PRIO) && pstrb[0]) begin
      int_prio_reg <= pwdata[7:0] & cmp_vref_pkg::INT_WRITABLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_flags_reg & int_en_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_hi_reg <= 1'b0;
    end else begin
      irq_hi_reg <= |(int_flags_reg & int_en_reg & int_prio_reg);
    end
  end

  // Asked only while asleep, so a running core sees no stray request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= sleep && |(int_flags_reg & int_en_reg);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Pins claimed by the oscillator read as zero
  always_comb begin
    port_view = port_a_pins;
    for (int i = 0; i < 4; i++) begin
      if (port_cfg_reg == cmp_vref_pkg::PORT_CFG_RESET) begin
        port_view[i] = 1'b0;
      end
    end
    if (osc_claims_pins) begin
      port_view[7:6] = 2'h0;
    end
  end

  assign cmp_rd = {res.result, cmp_ctrl_reg[5:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !pwrite) begin
      unique case (1'b1)
        hit(addr8, cmp_vref_pkg::OFS_CMP_CTRL): prdata_reg <= {24'h000000, cmp_rd};
        hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL): prdata_reg <= {24'h000000, vref_ctrl_reg};
        hit(addr8, cmp_vref_pkg::OFS_INT_FLAGS): prdata_reg <= {24'h000000, int_flags_reg};
        hit(addr8, cmp_vref_pkg::OFS_INT_EN): prdata_reg <= {24'h000000, int_en_reg};
        hit(addr8, cmp_vref_pkg::OFS_INT_PRIO): prdata_reg <= {24'h000000, int_prio_reg};
        hit(addr8, cmp_vref_pkg::OFS_PORT_CFG): prdata_reg <= {28'h0000000, port_cfg_reg};
        hit(addr8, cmp_vref_pkg::OFS_PORT_VIEW): prdata_reg <= {24'h000000, port_view};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Zero wait: the setup edge raises the answer, so it stands for the access phase only
  logic pready_reg;
  logic pslverr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
    end
  end

  // Unmapped offsets answer with an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup && !mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  //////////////////////////////////////////////////////////////////
  // Outputs to the analog side, interrupt and wake lines
  assign comparator_mode_field = cmp_ctrl_reg[2:0];
  assign comparator_input_switch = cmp_ctrl_reg[3];
  assign comparator_enable = cmp_en_reg;
  assign vref_power_enable = vref_ctrl_reg[cmp_vref_pkg::VREF_BIT_EN];
  assign vref_pin_output_enable = vref_ctrl_reg[cmp_vref_pkg::VREF_BIT_OE];
  assign vref_range_select = vref_ctrl_reg[cmp_vref_pkg::VREF_BIT_RANGE];
  assign vref_source_select = vref_ctrl_reg[cmp_vref_pkg::VREF_BIT_SRC];
  assign vref_level_code = vref_ctrl_reg[3:0];
  assign port_analog_config = port_cfg_reg;
  assign irq = irq_reg;
  assign irq_high_priority = irq_hi_reg;
  assign wake = wake_reg;

  //////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_off_a: assert property (
    cmp_ctrl_reg[2:0] == cmp_vref_pkg::MODE_OFF |=> cmp_en_reg == 2'h0)
    else $error("comparators on in off mode");

  result_off_a: assert property (
    cmp_ctrl_reg[2:0] == cmp_vref_pkg::MODE_OFF |=> res.result == 2'h0)
    else $error("result shown in off mode");

  sleep_run_a: assert property (
    sleep && cmp_ctrl_reg[2:0] != cmp_vref_pkg::MODE_OFF |=> cmp_en_reg == 2'h3)
    else $error("comparators stopped in sleep");

  sleep_irq_a: assert property (
    sleep && int_flags_reg[cmp_vref_pkg::INT_BIT_CMP] && int_en_reg[cmp_vref_pkg::INT_BIT_CMP]
    |=> irq)
    else $error("interrupt lost in sleep");

  wake_req_a: assert property (sleep && (int_flags_reg[6] && int_en_reg[6]) |=> wake)
    else $error("no wake on enabled interrupt");

  wake_none_a: assert property (!sleep |=> !wake)
    else $error("wake requested while awake");

  ctrl_hold_a: assert property (
    !(wr && hit(addr8, cmp_vref_pkg::OFS_CMP_CTRL)) |=> $stable(cmp_ctrl_reg))
    else $error("control changed without write");

  result_ro_a: assert property (cmp_ctrl_reg[7:6] == 2'h0)
    else $error("result bits stored");

  vref_wr_a: assert property (
    wr && pstrb[0] && hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL)
    |=> vref_level_code == $past(pwdata[3:0]) && vref_range_select == $past(pwdata[5]))
    else $error("reference write not applied");

  vref_bits_a: assert property (
    wr && pstrb[0] && hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL)
    |=> vref_power_enable == $past(pwdata[7]) && vref_pin_output_enable == $past(pwdata[6])
    && vref_source_select == $past(pwdata[4]))
    else $error("reference enables not applied");

  vref_indep_a: assert property (
    !(wr && hit(addr8, cmp_vref_pkg::OFS_VREF_CTRL)) |=> $stable(vref_ctrl_reg))
    else $error("reference changed without write");

  osc_pins_a: assert property (osc_claims_pins |-> port_view[7:6] == 2'h0)
    else $error("claimed pins not zero");

  port_analog_a: assert property (
    port_cfg_reg == cmp_vref_pkg::PORT_CFG_RESET |-> port_view[3:0] == 4'h0)
    else $error("analog pins read nonzero");

  flag_set_a: assert property (cmp_event |=> int_flags_reg[6])
    else $error("change flag not set");

  cover_wake_c: cover property (sleep ##1 wake);
  cover_change_c: cover property (cmp_event ##1 irq);
  cover_vref_c: cover property (vref_power_enable && vref_pin_output_enable);
  cover_ack_c: cover property (change_q && !res.change);
endmodule
`default_nettype wire

/* pkg/cmp_vref_pkg.sv */
/*
  Constants for the comparator and voltage reference control block:
  register offsets, field positions, reset values and mode codes.
  Assumes an APB slave with 32-bit data, one register per word.
*/
package cmp_vref_pkg;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h00;
  localparam logic [7:0] OFS_VREF_CTRL = 8'h04;
  localparam logic [7:0] OFS_INT_FLAGS = 8'h08;
  localparam logic [7:0] OFS_INT_EN = 8'h0C;
  localparam logic [7:0] OFS_INT_PRIO = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_PORT_CFG = 8'h18;
  localparam logic [7:0] OFS_PORT_VIEW = 8'h1C;
  localparam logic [7:0] CMP_CTRL_RESET = 8'h07;
  localparam logic [7:0] VREF_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_RESET = 8'h00;
  localparam logic [3:0] PORT_CFG_RESET = 4'h0;
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam int CMP_BIT_COMPARATOR2_RESULT = 7;
  localparam int CMP_BIT_COMPARATOR1_RESULT = 6;
  localparam int CMP_BIT_COMPARATOR2_INVERT = 5;
  localparam int CMP_BIT_COMPARATOR1_INVERT = 4;
  localparam int VREF_BIT_EN = 7;
  localparam int VREF_BIT_OE = 6;
  localparam int VREF_BIT_RANGE = 5;
  localparam int VREF_BIT_SRC = 4;
  localparam int INT_BIT_CMP = 6;
  localparam logic [7:0] INT_WRITABLE = 8'hDF;
  localparam logic [7:0] CMP_WRITABLE = 8'h3F;
  localparam int LEVELS = 16;
endpackage

/* pkg/cmp_res_if.sv */
/*
  Interface carrying comparator results from the result tracker to
  the main block. Assumes one clock, pclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface cmp_res_if;
  logic [1:0] result;
  logic change;
  logic ack;
  modport tracker (output result, output change, input ack);
  modport user (input result, input change, output ack);
endinterface
`default_nettype wire

/* core/cmp_result_track.sv */
/*
  Holds comparator results after inversion and flags a mismatch
  with the last value seen by software. Assumes raw comparator
  outputs already synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cmp_result_track (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] cmp_raw,
  input wire logic [1:0] invert,
  input wire logic cmp_on,
  cmp_res_if.tracker res
);
  logic [1:0] result_reg;
  logic [1:0] seen_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 2'h0;
    end else begin
      result_reg <= cmp_on ? (cmp_raw ^ invert) : 2'h0;
    end
  end

  // Mismatch lasts until software reads or writes the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 2'h0;
    end else if (res.ack) begin
      seen_reg <= result_reg;
    end
  end

  assign res.result = result_reg;
  assign res.change = (result_reg != seen_reg);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking testbench for the comparator and voltage reference
  control block, driven over APB with directed register sequences.
  Assumes the design package and interface are compiled first and
  that pready answers without a fixed wait count.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, err;
  logic sleep, osc_claims_pins;
  logic [1:0] cmp_raw, comparator_enable;
  logic [7:0] port_a_pins, v;
  logic [2:0] comparator_mode_field;
  logic comparator_input_switch, vref_power_enable, vref_pin_output_enable;
  logic vref_range_select, vref_source_select, irq, irq_high_priority, wake;
  logic [3:0] vref_level_code, port_analog_config;
  int num_errors = 0;
  int total_checks = 0;

  cmp_vref_ctrl #(.ADDR_W(8)) cmp_vref_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .osc_claims_pins(osc_claims_pins), .cmp_raw(cmp_raw),
    .port_a_pins(port_a_pins), .comparator_mode_field(comparator_mode_field),
    .comparator_input_switch(comparator_input_switch),
    .comparator_enable(comparator_enable), .vref_power_enable(vref_power_enable),
    .vref_pin_output_enable(vref_pin_output_enable),
    .vref_range_select(vref_range_select), .vref_source_select(vref_source_select),
    .vref_level_code(vref_level_code), .port_analog_config(port_analog_config),
    .irq(irq), .irq_high_priority(irq_high_priority), .wake(wake));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb_xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Registered outputs follow one edge after a write lands; checks read pre-edge values
  task automatic settle();
    @(posedge pclk);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    num_errors++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    sleep = 1'b0;
    osc_claims_pins = 1'b0;
    cmp_raw = 2'b00;
    port_a_pins = 8'hFF;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_out({5'h00, comparator_mode_field}, 8'h07);
    chk_out({6'h00, comparator_enable}, 8'h00);
    chk_out({4'h0, port_analog_config}, 8'h00);
    chk_out({vref_power_enable, vref_pin_output_enable, vref_range_select,
             vref_level_code}, 8'h00);
    rdr(cmp_vref_pkg::OFS_CMP_CTRL);
    chk_reg(rd, 32'h0000_0007);
    rdr(cmp_vref_pkg::OFS_VREF_CTRL);
    chk_reg(rd, 32'h0000_0000);
    // Comparators stay off meanwhile, so the reference stands alone
    for (int i = 0; i < 16; i++) begin
      v = 8'h80 | (8'(i[0]) << 5) | (8'(i[1]) << 4) | (8'(i[2]) << 6) | 8'(i);
      wr(cmp_vref_pkg::OFS_VREF_CTRL, {24'h000000, v});
      chk_out({4'h0, vref_level_code}, 8'(i));
      chk_out({6'h00, vref_range_select, vref_source_select},
              {6'h00, i[0], i[1]});
      chk_out({6'h00, vref_power_enable, vref_pin_output_enable},
              {6'h00, 1'b1, i[2]});
      rdr(cmp_vref_pkg::OFS_VREF_CTRL);
      chk_reg(rd, {24'h000000, v});
    end
    wr(cmp_vref_pkg::OFS_VREF_CTRL, 32'h0000_0000);
    chk_out({6'h00, vref_power_enable, vref_pin_output_enable}, 8'h00);
    // Result bits written as ones must not stick
    wr(cmp_vref_pkg::OFS_CMP_CTRL, 32'h0000_00C2);
    chk_out({5'h00, comparator_mode_field}, 8'h02);
    rdr(cmp_vref_pkg::OFS_CMP_CTRL);
    chk_reg(rd, 32'h0000_0002);
    wr(cmp_vref_pkg::OFS_INT_CLEAR, 32'h0000_00FF);
    wr(cmp_vref_pkg::OFS_INT_EN, 32'h0000_0040);
    rdr(cmp_vref_pkg::OFS_INT_FLAGS);
    chk_reg(rd, 32'h0000_0000);
    chk_out({6'h00, irq, wake}, 8'h00);
    sleep <= 1'b1;
    cmp_raw <= 2'b01;
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge pclk);
    settle();
    chk_out({6'h00, irq, wake}, 8'h03);
    rdr(cmp_vref_pkg::OFS_CMP_CTRL);
    chk_reg(rd, 32'h0000_0042);
    sleep <= 1'b0;
    rdr(cmp_vref_pkg::OFS_CMP_CTRL);
    chk_reg(rd, 32'h0000_0042);
    wr(cmp_vref_pkg::OFS_INT_CLEAR, 32'h0000_0040);
    settle();
    chk_out({6'h00, irq, wake}, 8'h00);
    // Flag set by software, then priority and masking
    wr(cmp_vref_pkg::OFS_INT_FLAGS, 32'h0000_0040);
    wr(cmp_vref_pkg::OFS_INT_PRIO, 32'h0000_0040);
    settle();
    chk_out({6'h00, irq, irq_high_priority}, 8'h03);
    wr(cmp_vref_pkg::OFS_INT_EN, 32'h0000_0000);
    settle();
    chk_out({6'h00, irq, irq_high_priority}, 8'h00);
    rdr(cmp_vref_pkg::OFS_INT_FLAGS);
    chk_reg(rd, 32'h0000_0040);
    wr(cmp_vref_pkg::OFS_INT_CLEAR, 32'h0000_0040);
    // Input switch set alongside the off code; both must show
    wr(cmp_vref_pkg::OFS_CMP_CTRL, 32'h0000_000F);
    settle();
    chk_out({6'h00, comparator_enable}, 8'h00);
    chk_out({4'h0, comparator_input_switch, comparator_mode_field}, 8'h0F);
    rdr(cmp_vref_pkg::OFS_CMP_CTRL);
    chk_reg(rd, 32'h0000_000F);
    rdr(8'h20);
    chk_reg({err, rd[30:0]}, 32'h8000_0000);
    rdr(cmp_vref_pkg::OFS_PORT_VIEW);
    chk_reg(rd, 32'h0000_00F0);
    wr(cmp_vref_pkg::OFS_PORT_CFG, 32'h0000_000F);
    chk_out({4'h0, port_analog_config}, 8'h0F);
    rdr(cmp_vref_pkg::OFS_PORT_VIEW);
    chk_reg(rd, 32'h0000_00FF);
    osc_claims_pins <= 1'b1;
    rdr(cmp_vref_pkg::OFS_PORT_VIEW);
    chk_reg(rd, 32'h0000_003F);
    give_verdict();
  end
endmodule
`default_nettype wire
